// ### verilog/synth_div_pkg.sv
// Package: constants for the synthesizer divider chain.
package synth_div_pkg;
  // ==========================================================================
  // Fixed ratios
  // ==========================================================================
  localparam int unsigned STD_TO_REF_DIV = 5;       // 5 MHz to 1 MHz
  localparam int unsigned REF_PRE_DIV = 5;          // 1 MHz to 200 kHz
  localparam int unsigned CMP_DIV = 400;            // 200 kHz to 500 Hz
  localparam int unsigned LF_OUT_DIV = 5;           // l.f. loop output divider
  localparam int unsigned HALF_DIV = 2;             // transfer and h.f. halvers
  // ==========================================================================
  // Programmable divider constants
  // ==========================================================================
  localparam int unsigned KHZ_TERMINAL = 46000;     // first divider terminal count
  localparam int unsigned MHZ_TOP = 99;             // second divider wrap point
  localparam int unsigned MHZ_TERMINAL = 39;        // second divider reset point
  localparam int unsigned MHZ_BASE = 40;            // added to the MHz setting
  localparam logic [3:0] MAX_TENS_DIGIT = 4'h2;     // highest MHz tens digit
  localparam logic [3:0] NINE = 4'h9;
  localparam int unsigned KHZ_W = 16;               // width of the first counter
  localparam int unsigned MHZ_W = 7;                // width of the second counter
  localparam int unsigned CLK_HZ = 50000000;        // system clock rate
endpackage : synth_div_pkg

// ### verilog/synth_fixed_div.sv
// Module: fixed-ratio divider producing a one-cycle tick per input ticks.
`timescale 1ns/1ns
`default_nettype none
module synth_fixed_div #(
  parameter int unsigned RATIO = 5
) (
  input wire logic clk,       // System clock.
  input wire logic rst,       // Synchronous reset, active high.
  input wire logic in_tick,   // Input event, one cycle.
  output logic out_tick       // One-cycle pulse every RATIO input events.
);
  localparam int unsigned CW = (RATIO > 1) ? $clog2(RATIO) : 1;
  localparam logic [CW-1:0] LAST = CW'(RATIO - 1);
  logic [CW-1:0] cnt_q;

  if (RATIO < 2) begin : g_bad_ratio
    $error("synth_fixed_div: RATIO must be at least 2.");
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (in_tick) begin
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end

  assign out_tick = in_tick && (cnt_q == LAST);
endmodule : synth_fixed_div
`default_nettype wire

// ### verilog/synth_programmable_dividers.sv
// Module: divider chain and both programmable dividers of the synthesizer.
`timescale 1ns/1ns
`default_nettype none
module synth_programmable_dividers
  import synth_div_pkg::*;
(
  input wire logic clk,                // System clock, 50 MHz.
  input wire logic rst,                // Synchronous reset, active high.
  input wire logic std_pin,            // 5 MHz standard, asynchronous.
  input wire logic lf_vco_pin,         // Low-frequency loop oscillator.
  input wire logic xfer_vco_pin,       // Transfer loop oscillator.
  input wire logic hf_vco_pin,         // High-frequency loop oscillator.
  input wire logic [3:0] dig_100hz,    // Selector digit, BCD.
  input wire logic [3:0] dig_1khz,     // Selector digit, BCD.
  input wire logic [3:0] dig_10khz,    // Selector digit, BCD.
  input wire logic [3:0] dig_100khz,   // Selector digit, BCD.
  input wire logic [3:0] dig_1mhz,     // MHz units digit, BCD.
  input wire logic [3:0] dig_10mhz,    // MHz tens digit, BCD 0 to 2.
  output logic ref_1mhz,               // 1 MHz reference tick.
  output logic ref_200khz,             // 200 kHz sub-carrier source tick.
  output logic ref_500hz,              // 500 Hz comparison tick.
  output logic khz_digit_divider,      // First divider output pulse.
  output logic lf_div5,                // Divided low loop output tick.
  output logic mhz_digit_divider,      // Transfer loop divider pulse.
  output logic xfer_half,              // Halved transfer loop, level.
  output logic hf_div_out,             // High loop divider pulse.
  output logic hf_fb,                  // Halved high loop feedback, level.
  output logic [15:0] khz_ratio,       // Ratio in force, first divider.
  output logic [6:0] mhz_ratio         // Ratio in force, second divider.
);
  // ==========================================================================
  // Input synchronisers and edge detection
  // ==========================================================================
  // Pins pass two flops; the edge detector compares the second stage with a one-cycle delayed copy of it.
  // The pins must toggle slower than a quarter of clk to be counted reliably.
  logic [3:0] pin_raw;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] prev_q;
  logic [3:0] rise;
  assign pin_raw = {hf_vco_pin, xfer_vco_pin, lf_vco_pin, std_pin};

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  assign rise = sync2_q & ~prev_q;

  // ==========================================================================
  // Fixed reference chain
  // ==========================================================================
  logic tick_1m;
  logic tick_200k;
  logic tick_500;

  synth_fixed_div #(.RATIO(STD_TO_REF_DIV)) u_std_div (
    .clk(clk),
    .rst(rst),
    .in_tick(rise[0]),
    .out_tick(tick_1m)
  );
  synth_fixed_div #(.RATIO(REF_PRE_DIV)) u_pre_div (
    .clk(clk),
    .rst(rst),
    .in_tick(tick_1m),
    .out_tick(tick_200k)
  );
  synth_fixed_div #(.RATIO(CMP_DIV)) u_cmp_div (
    .clk(clk),
    .rst(rst),
    .in_tick(tick_200k),
    .out_tick(tick_500)
  );

  // ==========================================================================
  // First programmable divider (sub-MHz digits)
  // ==========================================================================
  function automatic logic [15:0] bcd4_to_bin(input logic [3:0] d3, input logic [3:0] d2,
                                              input logic [3:0] d1, input logic [3:0] d0);
    bcd4_to_bin = 16'(d3) * 16'd1000 + 16'(d2) * 16'd100 + 16'(d1) * 16'd10 + 16'(d0);
  endfunction : bcd4_to_bin

  localparam logic [15:0] KHZ_END = 16'(KHZ_TERMINAL);
  logic [15:0] khz_setting;
  logic [15:0] khz_cnt_q;
  logic [15:0] khz_ratio_q;
  logic khz_pulse_q;
  assign khz_setting = bcd4_to_bin(dig_100khz, dig_10khz, dig_1khz, dig_100hz);

  // Preset to the setting plus one, count up, reload on reaching 46000:
  // the cycle then spans 46000 minus the setting input events.
  always_ff @(posedge clk) begin
    if (rst) begin
      khz_cnt_q <= 16'h0001;
      khz_ratio_q <= KHZ_END;
      khz_pulse_q <= 1'b0;
    end else begin
      khz_pulse_q <= 1'b0;
      if (rise[1]) begin
        if (khz_cnt_q >= KHZ_END) begin
          khz_cnt_q <= khz_setting + 16'h0001;
          khz_ratio_q <= KHZ_END - khz_setting;
          khz_pulse_q <= 1'b1;
        end else begin
          khz_cnt_q <= khz_cnt_q + 16'h0001;
        end
      end
    end
  end

  // ==========================================================================
  // Low loop output divide-by-five
  // ==========================================================================
  logic lf_tick;
  synth_fixed_div #(.RATIO(LF_OUT_DIV)) u_lf_div (
    .clk(clk),
    .rst(rst),
    .in_tick(rise[1]),
    .out_tick(lf_tick)
  );

  // ==========================================================================
  // Second programmable dividers (MHz digits)
  // ==========================================================================
  // Tens digit is clamped so a faulty selector cannot push the start below 70.
  function automatic logic [6:0] mhz_start(input logic [3:0] tens, input logic [3:0] units);
    logic [3:0] t;
    logic [3:0] t9;
    logic [3:0] u9;
    t = (tens > MAX_TENS_DIGIT) ? MAX_TENS_DIGIT : tens;
    t9 = NINE - t;
    u9 = NINE - ((units > NINE) ? NINE : units);
    mhz_start = 7'(t9) * 7'd10 + 7'(u9);
  endfunction : mhz_start

  localparam logic [6:0] MHZ_END = 7'(MHZ_TERMINAL);
  localparam logic [6:0] MHZ_WRAP = 7'(MHZ_TOP);
  logic [6:0] mhz_load;
  logic [6:0] mhz_preset;
  logic [6:0] ratio_now;
  assign mhz_load = mhz_start(dig_10mhz, dig_1mhz);
  // The reload event itself occupies the start state, so the counter is preset one past it.
  // Otherwise the cycle would span one event too many, as in the first divider.
  assign mhz_preset = (mhz_load >= MHZ_WRAP) ? 7'd0 : mhz_load + 7'd1;
  // Events from load to 99, wrap, on to 39: 40 + setting.
  assign ratio_now = (MHZ_WRAP - mhz_load) + MHZ_END + 7'd1;

  // Index 0 is the transfer loop divider, index 1 the high loop divider.
  logic [1:0] md_in;
  logic [6:0] md_cnt_q [2];
  logic [1:0] md_pulse_q;
  logic [6:0] mhz_ratio_q;
  assign md_in = {rise[3], lf_tick};

  for (genvar i = 0; i < 2; i++) begin : g_mhz
    always_ff @(posedge clk) begin
      if (rst) begin
        // Preset for a setting of 00: one past 99, which wraps to zero.
        md_cnt_q[i] <= 7'd0;
        md_pulse_q[i] <= 1'b0;
      end else begin
        md_pulse_q[i] <= 1'b0;
        if (md_in[i]) begin
          if (md_cnt_q[i] == MHZ_END) begin
            md_cnt_q[i] <= mhz_preset;
            md_pulse_q[i] <= 1'b1;
          end else if (md_cnt_q[i] >= MHZ_WRAP) begin
            md_cnt_q[i] <= 7'd0;
          end else begin
            md_cnt_q[i] <= md_cnt_q[i] + 7'd1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mhz_ratio_q <= 7'(MHZ_BASE);
    end else if (md_in[0] && md_cnt_q[0] == MHZ_END) begin
      mhz_ratio_q <= ratio_now;
    end
  end

  // ==========================================================================
  // Divide-by-two stages and registered outputs
  // ==========================================================================
  logic xfer_half_q;
  logic hf_fb_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      xfer_half_q <= 1'b0;
      hf_fb_q <= 1'b0;
    end else begin
      if (rise[2]) xfer_half_q <= ~xfer_half_q;
      if (md_pulse_q[1]) hf_fb_q <= ~hf_fb_q;
    end
  end

  logic [2:0] ref_q;
  logic lf_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_q <= '0;
      lf_q <= 1'b0;
    end else begin
      ref_q <= {tick_500, tick_200k, tick_1m};
      lf_q <= lf_tick;
    end
  end

  assign ref_1mhz = ref_q[0];
  assign ref_200khz = ref_q[1];
  assign ref_500hz = ref_q[2];
  assign lf_div5 = lf_q;
  assign khz_digit_divider = khz_pulse_q;
  assign mhz_digit_divider = md_pulse_q[0];
  assign hf_div_out = md_pulse_q[1];
  assign xfer_half = xfer_half_q;
  assign hf_fb = hf_fb_q;
  assign khz_ratio = khz_ratio_q;
  assign mhz_ratio = mhz_ratio_q;
endmodule : synth_programmable_dividers
`default_nettype wire

// ### test/synth_div_chk_sva.sv
// Checker: timing and range properties of the synthesizer divider chain.
`timescale 1ns/1ns
`default_nettype none
module synth_div_chk (
  input wire logic clk,                // Clock.
  input wire logic rst,                // Reset.
  input wire logic ref_1mhz,           // Watched pulse.
  input wire logic ref_200khz,         // Watched pulse.
  input wire logic lf_div5,            // Watched pulse.
  input wire logic mhz_digit_divider,  // Watched pulse.
  input wire logic xfer_half,          // Watched level.
  input wire logic hf_div_out,         // Watched pulse.
  input wire logic hf_fb,              // Watched level.
  input wire logic [15:0] khz_ratio,   // Watched ratio.
  input wire logic [6:0] mhz_ratio     // Watched ratio.
);
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Input pins need four clocks per event, so pulses are never adjacent.
  sequence s_idle8(logic s);
    (!s)[*8];
  endsequence
  property p_rst_val;
    disable iff (1'b0) rst |=> khz_ratio == 16'hb3b0 && mhz_ratio == 7'h28 && !hf_fb && !xfer_half;
  endproperty
  property p_khz_rng;
    khz_ratio >= 16'h8ca1 && khz_ratio <= 16'hb3b0;
  endproperty
  property p_mhz_rng;
    mhz_ratio >= 7'h28 && mhz_ratio <= 7'h45;
  endproperty
  property p_ref1;
    ref_1mhz |=> s_idle8(ref_1mhz);
  endproperty
  property p_ref200;
    ref_200khz |=> s_idle8(ref_200khz);
  endproperty
  property p_lf5;
    lf_div5 |=> s_idle8(lf_div5);
  endproperty
  property p_mhz_src;
    mhz_digit_divider |-> lf_div5 || $past(lf_div5) || $past(lf_div5, 2);
  endproperty
  property p_xfer;
    $changed(xfer_half) |=> $stable(xfer_half)[*3];
  endproperty
  property p_hf_fb;
    $changed(hf_fb) |-> hf_div_out || $past(hf_div_out);
  endproperty
  property p_reload;
    $changed(mhz_ratio) |-> $past(mhz_digit_divider) or ##[0:1] mhz_digit_divider;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset values wrong");
  a_khz_rng: assert property (p_khz_rng) else $error("first ratio out of range");
  a_mhz_rng: assert property (p_mhz_rng) else $error("second ratio out of range");
  a_ref1: assert property (p_ref1) else $error("1 MHz ticks too close");
  a_ref200: assert property (p_ref200) else $error("200 kHz ticks too close");
  a_lf5: assert property (p_lf5) else $error("low loop ticks too close");
  a_mhz_src: assert property (p_mhz_src) else $error("second divider pulse without input tick");
  a_xfer: assert property (p_xfer) else $error("halved transfer level toggles too fast");
  a_hf_fb: assert property (p_hf_fb) else $error("feedback toggled without divider pulse");
  a_reload: assert property (p_reload) else $error("ratio changed away from reload");
endmodule : synth_div_chk
bind synth_programmable_dividers synth_div_chk i_chk (
  .clk(clk), .rst(rst), .ref_1mhz(ref_1mhz), .ref_200khz(ref_200khz), .lf_div5(lf_div5),
  .mhz_digit_divider(mhz_digit_divider), .xfer_half(xfer_half), .hf_div_out(hf_div_out),
  .hf_fb(hf_fb), .khz_ratio(khz_ratio), .mhz_ratio(mhz_ratio)
);
`default_nettype wire

// ### test/front_panel_sel.sv
// Partner: front-panel decimal selector switches presenting BCD digits.
`timescale 1ns/1ns
`default_nettype none
module front_panel_sel (
  input wire logic [13:0] khz_set,  // Sub-MHz setting, 0 to 9999.
  input wire logic [4:0] mhz_set,   // MHz setting, 0 to 29.
  output logic [3:0] dig_100hz,     // Digit.
  output logic [3:0] dig_1khz,      // Digit.
  output logic [3:0] dig_10khz,     // Digit.
  output logic [3:0] dig_100khz,    // Digit.
  output logic [3:0] dig_1mhz,      // MHz units digit.
  output logic [3:0] dig_10mhz      // MHz tens digit.
);
  // ==========================================================================
  // Switch decoding
  // ==========================================================================
  always_comb begin
    dig_100hz = 4'(khz_set % 10);
    dig_1khz = 4'((khz_set / 10) % 10);
    dig_10khz = 4'((khz_set / 100) % 10);
    dig_100khz = 4'((khz_set / 1000) % 10);
    dig_1mhz = 4'(mhz_set % 10);
    // The tens wheel has a mechanical stop at two.
    dig_10mhz = (mhz_set > 5'd29) ? 4'h2 : 4'(mhz_set / 10);
  end
endmodule : front_panel_sel
`default_nettype wire

// ### test/synth_programmable_dividers_tb_top.sv
// Testbench: divider chain against an integer model of edge counts.
`timescale 1ns/1ns
`default_nettype none
module synth_programmable_dividers_tb_top;
  logic clk, rst, std_pin, lf_vco_pin, xfer_vco_pin, hf_vco_pin;
  logic [13:0] khz_set;
  logic [4:0] mhz_set;
  logic [3:0] dig_100hz, dig_1khz, dig_10khz, dig_100khz, dig_1mhz, dig_10mhz;
  logic ref_1mhz, ref_200khz, ref_500hz, khz_digit_divider, lf_div5, mhz_digit_divider;
  logic xfer_half, hf_div_out, hf_fb;
  logic [15:0] khz_ratio;
  logic [6:0] mhz_ratio;
  int errors, num_checks, std_n, xfer_n, c_1m, c_200k, c_500, c_khz, c_lf5, c_mhz, c_hf, cur, lf_n, b_m, b_h;
  bit run_bg, bg_done;
  int settings[$] = '{29, 0, 9, 12, 20};
  synth_programmable_dividers i_dut (
    .clk(clk), .rst(rst), .std_pin(std_pin), .lf_vco_pin(lf_vco_pin), .xfer_vco_pin(xfer_vco_pin),
    .hf_vco_pin(hf_vco_pin), .dig_100hz(dig_100hz), .dig_1khz(dig_1khz), .dig_10khz(dig_10khz),
    .dig_100khz(dig_100khz), .dig_1mhz(dig_1mhz), .dig_10mhz(dig_10mhz), .ref_1mhz(ref_1mhz),
    .ref_200khz(ref_200khz), .ref_500hz(ref_500hz), .khz_digit_divider(khz_digit_divider),
    .lf_div5(lf_div5), .mhz_digit_divider(mhz_digit_divider), .xfer_half(xfer_half),
    .hf_div_out(hf_div_out), .hf_fb(hf_fb), .khz_ratio(khz_ratio), .mhz_ratio(mhz_ratio)
  );
  front_panel_sel i_sel (
    .khz_set(khz_set), .mhz_set(mhz_set), .dig_100hz(dig_100hz), .dig_1khz(dig_1khz),
    .dig_10khz(dig_10khz), .dig_100khz(dig_100khz), .dig_1mhz(dig_1mhz), .dig_10mhz(dig_10mhz)
  );
  // ==========================================================================
  // Clock, counters and checking
  // ==========================================================================
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    if (!rst) begin
      c_1m += ref_1mhz;
      c_200k += ref_200khz;
      c_500 += ref_500hz;
      c_khz += khz_digit_divider;
      c_lf5 += lf_div5;
      c_mhz += mhz_digit_divider;
      c_hf += hf_div_out;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // Drives low loop and high loop edges side by side, with random widths.
  task automatic drive(input int nl, input int nh);
    int h;
    for (int i = 0; i < (nl > nh ? nl : nh); i++) begin
      h = 2 + $urandom % 2;
      lf_vco_pin = (i < nl);
      hf_vco_pin = (i < nh);
      repeat (h) @(negedge clk);
      lf_vco_pin = 0;
      hf_vco_pin = 0;
      repeat (h) @(negedge clk);
    end
  endtask : drive
  initial begin
    wait (run_bg);
    while (run_bg) begin
      @(negedge clk);
      std_pin = 1;
      xfer_vco_pin = 1;
      std_n++;
      xfer_n++;
      repeat (2 + $urandom % 2) @(negedge clk);
      std_pin = 0;
      xfer_vco_pin = 0;
      repeat (2) @(negedge clk);
    end
    bg_done = 1;
  end
  initial begin
    repeat (95000) @(posedge clk);
    errors++;
    wrap_up;
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst = 1;
    {std_pin, lf_vco_pin, xfer_vco_pin, hf_vco_pin} = 4'h0;
    khz_set = 14'h0;
    mhz_set = 5'h0;
    void'($urandom(32'h3cac));
    khz_set = 14'($urandom % 10000);
    settings.push_back($urandom % 30);
    repeat (6) @(negedge clk);
    rst = 0;
    @(negedge clk);
    chk(khz_ratio, 46000);
    chk(mhz_ratio, 40);
    chk({ref_1mhz, ref_200khz, ref_500hz, hf_fb, xfer_half}, 0);
    run_bg = 1;
    cur = 40;
    foreach (settings[k]) begin
      mhz_set = 5'(settings[k]);
      b_m = c_mhz;
      b_h = c_hf;
      drive(cur * 5 - 1, cur - 1);
      repeat (8) @(negedge clk);
      chk(c_mhz - b_m, 0);
      chk(c_hf - b_h, 0);
      drive(1, 1);
      repeat (8) @(negedge clk);
      chk(c_mhz - b_m, 1);
      chk(c_hf - b_h, 1);
      chk(hf_fb, (k + 1) % 2);
      lf_n += cur * 5;
      cur = 40 + settings[k];
      chk(mhz_ratio, cur);
    end
    chk(c_lf5, lf_n / 5);
    chk(c_khz, 0);
    chk(khz_ratio, 46000);
    wait (std_n >= 10005);
    run_bg = 0;
    wait (bg_done);
    repeat (10) @(negedge clk);
    chk(c_1m, std_n / 5);
    chk(c_200k, std_n / 25);
    chk(c_500, std_n / 10000);
    chk(xfer_half, xfer_n % 2);
    wrap_up;
  end
endmodule : synth_programmable_dividers_tb_top
`default_nettype wire
